// *** ldc_lead_off_control.sv ***
module ldc_lead_off_control #(
  parameter int ELECTRODES = 6
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clkEn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic calDacEnable,
  output logic dcDetectActive,
  output logic [ELECTRODES-1:0] acElectrodeEnable,
  output logic [9:0] acCurrentTenthsNa,
  output logic [6:0] dcCurrentNa,
  output logic [1:0] ac_test_current_level,
  output logic [2:0] dc_test_current_level
);

  typedef struct packed {
    ldc_pkg::ldc_phase_e phase;
    logic wrPend;
    logic [31:0] addr;
    logic [23:0] lead_off_control;
    logic [31:0] rdata;
    logic dcActive;
    logic [ELECTRODES-1:0] acEn;
    logic [9:0] acNa;
    logic [6:0] dcNa;
  } ldc_state_s;

  ldc_state_s state;
  ldc_state_s next_state;

  logic global_ac_detect_select;
  logic lead_off_detect_enable;
  logic left_arm_ac_enable;
  logic common_electrode_ac_enable;
  logic [ELECTRODES-1:0] elecBits;
  logic [ELECTRODES-1:0] globalMask;
  logic [ELECTRODES-1:0] acRaw;
  logic addrPhase;

  // Field views of the stored register
  assign global_ac_detect_select = state.lead_off_control[ldc_pkg::ACSELECT_BIT];
  assign lead_off_detect_enable = state.lead_off_control[ldc_pkg::ENABLE_BIT];
  assign elecBits = state.lead_off_control[ldc_pkg::ELEC_MSB:ldc_pkg::ELEC_LSB];
  assign left_arm_ac_enable = elecBits[ELECTRODES-1];
  assign common_electrode_ac_enable = elecBits[ldc_pkg::CE_INDEX];
  assign ac_test_current_level = state.lead_off_control[ldc_pkg::AC_MSB:ldc_pkg::AC_LSB];
  assign dc_test_current_level = state.lead_off_control[ldc_pkg::DC_MSB:ldc_pkg::DC_LSB];
  assign addrPhase = hsel && hready && htrans[1];

  // Per-electrode ac enable: global select reaches all but the common electrode
  genvar g;
  generate
    for (g = 0; g < ELECTRODES; g++) begin : gElec
      if (g == ldc_pkg::CE_INDEX) begin : gCe
        assign globalMask[g] = 1'b0;
      end else begin : gOther
        assign globalMask[g] = global_ac_detect_select;
      end
      // OR select with own bit; both count only with lead-off enabled
      assign acRaw[g] = lead_off_detect_enable && (globalMask[g] || elecBits[g]);
    end
  endgenerate

  // Next-state logic: bus slave plus decoded detection controls
  always_comb begin
    next_state = state;
    if (state.phase == ldc_pkg::LDC_DATA && state.wrPend) begin
      if (state.addr == ldc_pkg::LEAD_OFF_CONTROL_ADDR) begin
        next_state.lead_off_control = hwdata[23:0] & ldc_pkg::WRITE_MASK;
      end
    end
    next_state.wrPend = 1'b0;
    next_state.phase = ldc_pkg::LDC_IDLE;
    if (addrPhase) begin
      next_state.phase = ldc_pkg::LDC_DATA;
      next_state.wrPend = hwrite;
      next_state.addr = haddr;
      // Control register reads return zero above bit 23 and in reserved bits
      if (haddr == ldc_pkg::LEAD_OFF_CONTROL_ADDR) begin
        next_state.rdata = {8'h00, next_state.lead_off_control};
      end else if (haddr == ldc_pkg::EFFECTIVE_STATE_ADDR) begin
        // Effective state: ac enables, dc active, ac level, dc level, zero above
        next_state.rdata = {7'h00, state.dcNa, state.acNa, 1'b0, state.dcActive,
                            6'(state.acEn)};
      end else begin
        next_state.rdata = 32'h0000_0000;
      end
    end
    // DC detection only when enabled and select clear
    next_state.dcActive = lead_off_detect_enable && !global_ac_detect_select;
    next_state.acEn = calDacEnable ? '0 : acRaw;
    // AC level decode
    case (ac_test_current_level)
      2'h0: next_state.acNa = ldc_pkg::AC_LEVEL_00;
      2'h1: next_state.acNa = ldc_pkg::AC_LEVEL_01;
      2'h2: next_state.acNa = ldc_pkg::AC_LEVEL_10;
      default: next_state.acNa = ldc_pkg::AC_LEVEL_11;
    endcase
    // DC level linear in steps; zero when not applied
    if (next_state.dcActive) begin
      next_state.dcNa = 7'(dc_test_current_level * ldc_pkg::DC_STEP_NA);
    end else begin
      next_state.dcNa = 7'h00;
    end
  end

  // State register with synchronous reset and clock enable
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state.phase <= ldc_pkg::LDC_IDLE;
      state.wrPend <= 1'b0;
      state.addr <= 32'h0000_0000;
      state.lead_off_control <= ldc_pkg::LEAD_OFF_CONTROL_RESET;
      state.rdata <= 32'h0000_0000;
      state.dcActive <= 1'b0;
      state.acEn <= '0;
      state.acNa <= ldc_pkg::AC_LEVEL_00;
      state.dcNa <= 7'h00;
    end else if (clkEn) begin
      state <= next_state;
    end
  end

  // Outputs
  assign hrdata = state.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign dcDetectActive = state.dcActive;
  assign acElectrodeEnable = state.acEn;
  assign acCurrentTenthsNa = state.acNa;
  assign dcCurrentNa = state.dcNa;

  // Checks on the dc and ac detection modes
  a_dc_when_select: assert property (@(posedge clk_sys) disable iff (rst)
    clkEn && lead_off_detect_enable && global_ac_detect_select |=> !dcDetectActive)
    else $error("dc active with global ac select");

  a_dc_on_enabled: assert property (@(posedge clk_sys) disable iff (rst)
    clkEn && lead_off_detect_enable && !global_ac_detect_select |=> dcDetectActive)
    else $error("dc not active when expected");

  a_off_no_detect: assert property (@(posedge clk_sys) disable iff (rst)
    clkEn && !lead_off_detect_enable |=> !dcDetectActive && acElectrodeEnable == '0)
    else $error("detection while disabled");

  a_off_dc_zero: assert property (@(posedge clk_sys) disable iff (rst)
    clkEn && !lead_off_detect_enable |=> dcCurrentNa == 7'h00)
    else $error("dc current while disabled");

  a_sel_ignored: assert property (@(posedge clk_sys) disable iff (rst)
    clkEn && !lead_off_detect_enable && global_ac_detect_select |=> acElectrodeEnable == '0)
    else $error("global select acted while disabled");

  a_cal_kills_ac: assert property (@(posedge clk_sys) disable iff (rst)
    clkEn && calDacEnable |=> acElectrodeEnable == '0)
    else $error("ac enabled with calibration on");

  a_ce_not_global: assert property (@(posedge clk_sys) disable iff (rst)
    clkEn && !common_electrode_ac_enable |=> !acElectrodeEnable[ldc_pkg::CE_INDEX])
    else $error("CE ac enabled by global select");

  a_global_all: assert property (@(posedge clk_sys) disable iff (rst)
    clkEn && lead_off_detect_enable && global_ac_detect_select && !calDacEnable
    |=> &acElectrodeEnable[ELECTRODES-1:1])
    else $error("global select missed an electrode");

  a_ac_or_rule: assert property (@(posedge clk_sys) disable iff (rst)
    clkEn && lead_off_detect_enable && !calDacEnable && left_arm_ac_enable
    |=> acElectrodeEnable[ELECTRODES-1])
    else $error("individual ac enable lost");

  a_ce_own_bit: assert property (@(posedge clk_sys) disable iff (rst)
    clkEn && lead_off_detect_enable && !calDacEnable && common_electrode_ac_enable
    |=> acElectrodeEnable[ldc_pkg::CE_INDEX])
    else $error("common electrode own enable lost");

  // With lead-off enabled and calibration off, per-electrode ac enable follows the OR of own bit and global select, which skips the common electrode
  genvar e;
  generate
    for (e = 0; e < ELECTRODES; e++) begin : gElecChk
      a_elec_own: assert property (@(posedge clk_sys) disable iff (rst)
        clkEn && lead_off_detect_enable && !calDacEnable && elecBits[e]
        |=> acElectrodeEnable[e])
        else $error("electrode own ac enable lost");
      a_elec_idle: assert property (@(posedge clk_sys) disable iff (rst)
        clkEn && !elecBits[e] && !(global_ac_detect_select && e != ldc_pkg::CE_INDEX)
        |=> !acElectrodeEnable[e])
        else $error("electrode ac enabled without cause");
    end
  endgenerate

  // Current level decodes
  a_dc_zero_in_ac: assert property (@(posedge clk_sys) disable iff (rst)
    clkEn && global_ac_detect_select |=> dcCurrentNa == 7'h00)
    else $error("dc current applied with ac select");

  a_dc_level: assert property (@(posedge clk_sys) disable iff (rst)
    clkEn && lead_off_detect_enable && !global_ac_detect_select && dc_test_current_level == 3'h7
    |=> dcCurrentNa == 7'h46)
    else $error("dc level decode wrong");

  // One dc level check per code, one step apart
  genvar dcCode;
  generate
    for (dcCode = 0; dcCode < (1 << (ldc_pkg::DC_MSB - ldc_pkg::DC_LSB + 1)); dcCode++)
    begin : gDcCode
      a_dc_code: assert property (@(posedge clk_sys) disable iff (rst)
        clkEn && lead_off_detect_enable && !global_ac_detect_select
        && dc_test_current_level == 3'(dcCode)
        |=> dcCurrentNa == 7'(dcCode) * ldc_pkg::DC_STEP_NA)
        else $error("dc step decode wrong");
    end
  endgenerate

  a_ac_level: assert property (@(posedge clk_sys) disable iff (rst)
    clkEn && ac_test_current_level == 2'h3 |=> acCurrentTenthsNa == ldc_pkg::AC_LEVEL_11)
    else $error("ac level decode wrong");

  a_ac_level_00: assert property (@(posedge clk_sys) disable iff (rst)
    clkEn && ac_test_current_level == 2'h0 |=> acCurrentTenthsNa == ldc_pkg::AC_LEVEL_00)
    else $error("ac lowest level decode wrong");

  a_ac_level_01: assert property (@(posedge clk_sys) disable iff (rst)
    clkEn && ac_test_current_level == 2'h1 |=> acCurrentTenthsNa == ldc_pkg::AC_LEVEL_01)
    else $error("ac second level decode wrong");

  a_ac_level_10: assert property (@(posedge clk_sys) disable iff (rst)
    clkEn && ac_test_current_level == 2'h2 |=> acCurrentTenthsNa == ldc_pkg::AC_LEVEL_10)
    else $error("ac third level decode wrong");

  // Reset values
  a_reset_zero: assert property (@(posedge clk_sys)
    rst |=> state.lead_off_control == ldc_pkg::LEAD_OFF_CONTROL_RESET)
    else $error("register not zero after reset");

  a_reset_outputs: assert property (@(posedge clk_sys)
    rst |=> acElectrodeEnable == '0 && !dcDetectActive && dcCurrentNa == 7'h00)
    else $error("detection outputs not idle after reset");

  a_reset_ac_level: assert property (@(posedge clk_sys)
    rst |=> acCurrentTenthsNa == ldc_pkg::AC_LEVEL_00)
    else $error("ac level not lowest after reset");

  // Register bus: writes land, reads return what the register holds
  a_reserved_zero: assert property (@(posedge clk_sys) disable iff (rst)
    (state.lead_off_control & ~ldc_pkg::WRITE_MASK) == 24'h00_0000)
    else $error("reserved bits set");

  a_write_lands: assert property (@(posedge clk_sys) disable iff (rst)
    clkEn && state.phase == ldc_pkg::LDC_DATA && state.wrPend
    && state.addr == ldc_pkg::LEAD_OFF_CONTROL_ADDR
    |=> state.lead_off_control == ($past(hwdata[23:0]) & ldc_pkg::WRITE_MASK))
    else $error("register write lost");

  a_unmapped_write: assert property (@(posedge clk_sys) disable iff (rst)
    clkEn && state.phase == ldc_pkg::LDC_DATA && state.wrPend
    && state.addr != ldc_pkg::LEAD_OFF_CONTROL_ADDR |=> $stable(state.lead_off_control))
    else $error("unmapped write changed the register");

  a_read_reg: assert property (@(posedge clk_sys) disable iff (rst)
    clkEn && addrPhase && !hwrite && haddr == ldc_pkg::LEAD_OFF_CONTROL_ADDR
    && !(state.phase == ldc_pkg::LDC_DATA && state.wrPend)
    |=> hrdata == {8'h00, $past(state.lead_off_control)})
    else $error("register read wrong");

  a_read_upper_zero: assert property (@(posedge clk_sys) disable iff (rst)
    state.phase == ldc_pkg::LDC_DATA && state.addr == ldc_pkg::LEAD_OFF_CONTROL_ADDR
    |-> hrdata[31:24] == 8'h00)
    else $error("upper read bits not zero");

  a_read_unmapped: assert property (@(posedge clk_sys) disable iff (rst)
    clkEn && addrPhase && haddr == ldc_pkg::ENGINE_CONFIG_ADDR |=> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  a_eff_dc_read: assert property (@(posedge clk_sys) disable iff (rst)
    clkEn && addrPhase && haddr == ldc_pkg::EFFECTIVE_STATE_ADDR
    |=> hrdata[6] == $past(dcDetectActive))
    else $error("state word dc flag wrong");

  a_eff_ac_read: assert property (@(posedge clk_sys) disable iff (rst)
    clkEn && addrPhase && haddr == ldc_pkg::EFFECTIVE_STATE_ADDR
    |=> hrdata[5:0] == 6'($past(acElectrodeEnable)))
    else $error("state word ac enables wrong");

  a_eff_upper_zero: assert property (@(posedge clk_sys) disable iff (rst)
    clkEn && addrPhase && haddr == ldc_pkg::EFFECTIVE_STATE_ADDR
    |=> hrdata[31:25] == 7'h00 && !hrdata[7])
    else $error("state word spare bits set");

  // Read data stands and state holds while nothing moves it
  a_rdata_stands: assert property (@(posedge clk_sys) disable iff (rst)
    clkEn && !addrPhase |=> $stable(hrdata))
    else $error("read data moved without a request");

  a_frozen_state: assert property (@(posedge clk_sys) disable iff (rst)
    !clkEn |=> $stable(state))
    else $error("state moved with clock enable low");

  // Main scenarios
  c_global_ac: cover property (@(posedge clk_sys)
    lead_off_detect_enable && global_ac_detect_select);
  c_dc_mode: cover property (@(posedge clk_sys) dcDetectActive && dcCurrentNa != 7'h00);
  c_cal_override: cover property (@(posedge clk_sys) calDacEnable && |acRaw);
  c_ce_individual: cover property (@(posedge clk_sys)
    acElectrodeEnable[ldc_pkg::CE_INDEX] && !global_ac_detect_select);
  c_reg_write: cover property (@(posedge clk_sys)
    state.phase == ldc_pkg::LDC_DATA && state.wrPend);
endmodule

// *** ldc_lead_off_control_tb_top.sv ***
`define CHK(act, exp) begin total_checks++; if ((act) !== (exp)) begin fail_count++; \
  $display("ERROR t=%0t got=%0h exp=%0h", $time, (act), (exp)); end end

module ldc_lead_off_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic clkEn = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic calDacEnable = 1'b0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, dcDetectActive;
  logic [5:0] acElectrodeEnable;
  logic [9:0] acCurrentTenthsNa;
  logic [6:0] dcCurrentNa;
  logic [1:0] ac_test_current_level;
  logic [2:0] dc_test_current_level;
  logic [31:0] rd;
  int fail_count = 0;
  int total_checks = 0;

  // Free-running system clock, 25 ns period
  always #12.5 clk_sys = ~clk_sys;

  ldc_lead_off_control #(.ELECTRODES(6)) u_ldc_lead_off_control (
    .clk_sys(clk_sys), .rst(rst), .clkEn(clkEn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .calDacEnable(calDacEnable),
    .dcDetectActive(dcDetectActive), .acElectrodeEnable(acElectrodeEnable),
    .acCurrentTenthsNa(acCurrentTenthsNa), .dcCurrentNa(dcCurrentNa),
    .ac_test_current_level(ac_test_current_level),
    .dc_test_current_level(dc_test_current_level));

  // One single-word transfer: address phase, then data phase, read data taken at its end
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    hsel <= 1'b1; haddr <= a; htrans <= ldc_pkg::HTRANS_NONSEQ; hwrite <= wr;
    hsize <= ldc_pkg::HSIZE_WORD;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'h0; hsel <= 1'b0; hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
    `CHK(hresp, 1'b0)
  endtask

  // Expected effective-state word for a register value and calibration DAC state
  function automatic logic [31:0] est(input logic [17:0] r, input logic cal);
    logic dc;
    logic [5:0] ac;
    logic [9:0] act;
    logic [6:0] dcn;
    dc = r[0] & ~r[1];
    ac = (r[0] & ~cal) ? (r[17:12] | (r[1] ? 6'h3E : 6'h00)) : 6'h00;
    case (r[8:7])
      2'h0: act = ldc_pkg::AC_LEVEL_00;
      2'h1: act = ldc_pkg::AC_LEVEL_01;
      2'h2: act = ldc_pkg::AC_LEVEL_10;
      default: act = ldc_pkg::AC_LEVEL_11;
    endcase
    dcn = dc ? 7'(r[4:2]) * ldc_pkg::DC_STEP_NA : 7'h00;
    return {7'h00, dcn, act, 1'b0, dc, ac};
  endfunction

  // Waits one edge for derived outputs, compares ports and the read-only state word
  task automatic chk_state(input logic [17:0] r, input logic cal);
    logic [31:0] e;
    e = est(r, cal);
    @(posedge clk_sys);
    #1;
    `CHK({7'h00, dcCurrentNa, acCurrentTenthsNa, 1'b0, dcDetectActive, acElectrodeEnable}, e)
    `CHK({ac_test_current_level, dc_test_current_level}, {r[8:7], r[4:2]})
    ahb(1'b0, ldc_pkg::EFFECTIVE_STATE_ADDR, 32'h0000_0000);
    `CHK(rd, e)
  endtask

  // Reset content of the control register and idle outputs
  task automatic t_reset;
    ahb(1'b0, ldc_pkg::LEAD_OFF_CONTROL_ADDR, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    chk_state(18'h0_0000, 1'b0);
  endtask

  // Every ac and dc level code, with readback after the state check
  task automatic t_levels;
    logic [17:0] r;
    for (int i = 0; i < 8; i++) begin
      r = {9'h000, 2'(i % 4), 2'h0, 3'(i), 2'b01};
      ahb(1'b1, ldc_pkg::LEAD_OFF_CONTROL_ADDR, 32'(r));
      chk_state(r, 1'b0);
      ahb(1'b0, ldc_pkg::LEAD_OFF_CONTROL_ADDR, 32'h0000_0000);
      `CHK(rd, 32'(r))
    end
  endtask

  // All combinations of enable, global select and calibration DAC
  task automatic t_modes;
    logic [17:0] r;
    for (int m = 0; m < 8; m++) begin
      r = {6'h21, 3'h0, 2'h2, 2'h0, 3'h5, 1'(m >> 1), 1'(m)};
      ahb(1'b1, ldc_pkg::LEAD_OFF_CONTROL_ADDR, 32'(r));
      calDacEnable <= 1'(m >> 2);
      chk_state(r, 1'(m >> 2));
    end
    calDacEnable <= 1'b0;
  endtask

  // Reserved bits, unmapped address and frozen clock enable
  task automatic t_reserved;
    ahb(1'b1, ldc_pkg::LEAD_OFF_CONTROL_ADDR, 32'hFFFF_FFFF);
    chk_state(18'h3_F19F, 1'b0);
    ahb(1'b0, ldc_pkg::LEAD_OFF_CONTROL_ADDR, 32'h0000_0000);
    `CHK(rd, 32'(ldc_pkg::WRITE_MASK))
    ahb(1'b1, ldc_pkg::ENGINE_CONFIG_ADDR, 32'hFFFF_FFFF);
    ahb(1'b0, ldc_pkg::ENGINE_CONFIG_ADDR, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    clkEn <= 1'b0;
    ahb(1'b1, ldc_pkg::LEAD_OFF_CONTROL_ADDR, 32'h0000_0000);
    clkEn <= 1'b1;
    ahb(1'b0, ldc_pkg::LEAD_OFF_CONTROL_ADDR, 32'h0000_0000);
    `CHK(rd, 32'(ldc_pkg::WRITE_MASK))
  endtask

  // Prints the counts and the verdict, then ends the run
  task automatic test_done;
    $display("checks=%0d errors=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Main sequence after eight cycles of reset
  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_levels();
    t_modes();
    t_reserved();
    test_done();
  end

  // Watchdog against a hung transfer
  initial begin
    repeat (5000) @(posedge clk_sys);
    fail_count++;
    test_done();
  end
endmodule

// *** ldc_pkg.sv ***
package ldc_pkg;
  // Register map; printed address 0x02 is not a multiple of four, so it is an index
  localparam logic [7:0] LEAD_OFF_CONTROL_INDEX = 8'h02;
  localparam logic [31:0] LEAD_OFF_CONTROL_ADDR = 32'h0000_0008;
  localparam logic [31:0] ENGINE_CONFIG_ADDR = 32'h0000_000C;
  localparam logic [31:0] EFFECTIVE_STATE_ADDR = 32'h0000_0010;
  localparam logic [23:0] LEAD_OFF_CONTROL_RESET = 24'h00_0000;
  // Field positions inside lead_off_control
  localparam int ENABLE_BIT = 0;
  localparam int ACSELECT_BIT = 1;
  localparam int DC_LSB = 2;
  localparam int DC_MSB = 4;
  localparam int AC_LSB = 7;
  localparam int AC_MSB = 8;
  localparam int ELEC_LSB = 12;
  localparam int ELEC_MSB = 17;
  localparam int ELEC_COUNT = 6;
  // Electrode order inside the enable vector; bit 0 is the common electrode
  localparam int CE_INDEX = 0;
  // Writable mask of the low part: enables, ac level, dc level, select, enable
  localparam logic [23:0] WRITE_MASK = 24'h03_F19F;
  // Current levels in tenths of a nA rms for ac, nA for dc
  localparam logic [9:0] AC_LEVEL_00 = 10'h07D;
  localparam logic [9:0] AC_LEVEL_01 = 10'h0FA;
  localparam logic [9:0] AC_LEVEL_10 = 10'h1F4;
  localparam logic [9:0] AC_LEVEL_11 = 10'h3E8;
  localparam logic [6:0] DC_STEP_NA = 7'h0A;
  // AHB-Lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  typedef enum logic [1:0] {
    LDC_IDLE = 2'b01,
    LDC_DATA = 2'b10
  } ldc_phase_e;
endpackage
